// *** core/cts_pkg.sv ***
// package: offsets, codes and state types for the calendar time-set block
package cts_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // request area (word addresses)
   localparam logic [15:0] OFS_REQ_COMMAND = 16'h68a0;
   localparam logic [15:0] OFS_REQ_YEAR = 16'h68a1;
   localparam logic [15:0] OFS_REQ_MONTH = 16'h68a2;
   localparam logic [15:0] OFS_REQ_DAY = 16'h68a3;
   localparam logic [15:0] OFS_REQ_HOUR = 16'h68a4;
   localparam logic [15:0] OFS_REQ_MINUTE = 16'h68a5;
   localparam logic [15:0] OFS_REQ_SECOND = 16'h68a6;
   localparam logic [15:0] OFS_REQ_MILLI = 16'h68a7;
   localparam logic [15:0] OFS_REQ_CLK_STATUS = 16'h68a8;
   // response area
   localparam logic [15:0] OFS_RESP_CODE = 16'h68b0;
   localparam logic [15:0] OFS_RESP_PAD_FIRST = 16'h68b1;
   localparam logic [15:0] OFS_RESP_PAD_LAST = 16'h68bc;
   // control registers of this block
   localparam logic [15:0] OFS_CTRL = 16'h68c0;
   localparam logic [15:0] OFS_IRQ_STATUS = 16'h68c1;
   localparam logic [15:0] OFS_IRQ_MASK = 16'h68c2;
   localparam logic [15:0] OFS_ERR_LIMIT = 16'h68c3;
   // codes and limits
   localparam logic [15:0] CMD_CAL_SET = 16'h1602;
   localparam logic [15:0] RESP_CAL_DONE = 16'ha602;
   localparam logic [15:0] ERR_BAD_CMD = 16'hc001;
   localparam logic [15:0] ERR_BAD_RANGE = 16'hc002;
   localparam logic [15:0] PAD_VALUE = 16'h0000;
   localparam logic [15:0] YEAR_MIN = 16'h07c0;
   localparam logic [15:0] YEAR_MAX = 16'h07f4;
   localparam logic [15:0] MONTH_MIN = 16'h0001;
   localparam logic [15:0] MONTH_MAX = 16'h000c;
   localparam logic [15:0] DAY_MIN = 16'h0001;
   localparam logic [15:0] DAY_MAX = 16'h001f;
   localparam logic [15:0] HOUR_MAX = 16'h0017;
   localparam logic [15:0] MINSEC_MAX = 16'h003b;
   localparam logic [15:0] MILLI_MAX = 16'h03e7;
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [1:0] RST_IRQ = 2'b00;
   // irq status bits
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;

   typedef enum logic [1:0] {
      CTS_IDLE = 2'b00,
      CTS_CHECK = 2'b01,
      CTS_DONE = 2'b10
   } cts_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } cts_bus_req_t;

   typedef struct packed {
      logic [15:0] command;
      logic [15:0] year;
      logic [15:0] month;
      logic [15:0] day;
      logic [15:0] hour;
      logic [15:0] minute;
      logic [15:0] second;
      logic [15:0] milli;
      logic [15:0] clk_status;
   } cts_req_words_t;

   typedef struct packed {
      logic [15:0] year;
      logic [15:0] month;
      logic [15:0] day;
      logic [15:0] hour;
      logic [15:0] minute;
      logic [15:0] second;
      logic [15:0] milli;
      logic [15:0] clk_status;
      logic valid;
   } cts_time_out_t;
endpackage : cts_pkg

// *** core/cts_time_set.sv ***
// calendar time-set command interpreter on a shared buffer-memory port
//
// Notes on behaviour
// RULE1 - host writes command 1602h before start
// RULE2 - host writes year 1984 to 2036
// RULE3 - host writes month 1 to 12
// RULE4 - host writes day 1 to 31
// RULE5 - host writes hour 0 to 23
// RULE6 - host writes minute 0 to 59
// RULE7 - host writes second 0 to 59
// RULE8 - host writes millisecond 0 to 999
// RULE9 - host writes clock status, zero allowed
// RULE10 - success stores A602h in response word
// RULE11 - twelve following response words read zero
// RULE12 - failure stores error code instead
// RULE13 - host raises request after writing words
// RULE14 - device raises done after response written
// RULE15 - host drops request after reading response
// RULE16 - done drops after request drops
// RULE17 - out-of-range field gives error code
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module cts_time_set (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // register port
   input wire logic [cts_pkg::ADDR_W-1:0] bus_addr_i,
   input wire logic [cts_pkg::DATA_W-1:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   output logic [cts_pkg::DATA_W-1:0] bus_rdata_o,
   // handshake pins
   input wire logic time_set_request_flag_i,
   output logic time_set_done_flag_o,
   // time handed to the clock keeper
   output cts_pkg::cts_time_out_t time_set_o,
   // interrupt
   output logic irq_o
);
   import cts_pkg::*;

   typedef struct packed {
      cts_state_t state;
      cts_req_words_t req;
      logic [15:0] resp_code;
      logic done;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic enable;
      logic [15:0] err_count;
      logic [15:0] rdata;
      logic irq;
      logic [1:0] req_sync;
      cts_time_out_t tout;
   } cts_regs_t;

   cts_regs_t r;
   cts_regs_t next_r;
   cts_bus_req_t bus;
   logic req_lvl;
   logic range_ok;

   // bundle the register port for the decoders
   assign bus = '{addr: bus_addr_i, wdata: bus_wdata_i, wr: bus_wr_i, rd: bus_rd_i};
   assign req_lvl = r.req_sync[1];

   // inclusive bounds check on one word
   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   ////////////////////////////////////////////////////////////////////////////
   // range checks on the request words
   // day is not matched to month length
   always_comb begin
      range_ok = in_range(r.req.year, YEAR_MIN, YEAR_MAX) // see RULE17
         && in_range(r.req.month, MONTH_MIN, MONTH_MAX)
         && in_range(r.req.day, DAY_MIN, DAY_MAX)
         && in_range(r.req.hour, RST_WORD, HOUR_MAX)
         && in_range(r.req.minute, RST_WORD, MINSEC_MAX)
         && in_range(r.req.second, RST_WORD, MINSEC_MAX)
         && in_range(r.req.milli, RST_WORD, MILLI_MAX);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_r = r;
      next_r.req_sync = {r.req_sync[0], time_set_request_flag_i};
      next_r.tout.valid = 1'b0;
      next_r.rdata = RST_WORD;
      // request area writes, blocked while a command is in flight
      if (bus.wr && r.state == CTS_IDLE && !req_lvl) begin
         if (bus.addr == OFS_REQ_COMMAND) begin
            next_r.req.command = bus.wdata;
         end else if (bus.addr == OFS_REQ_YEAR) begin
            next_r.req.year = bus.wdata;
         end else if (bus.addr == OFS_REQ_MONTH) begin
            next_r.req.month = bus.wdata;
         end else if (bus.addr == OFS_REQ_DAY) begin
            next_r.req.day = bus.wdata;
         end else if (bus.addr == OFS_REQ_HOUR) begin
            next_r.req.hour = bus.wdata;
         end else if (bus.addr == OFS_REQ_MINUTE) begin
            next_r.req.minute = bus.wdata;
         end else if (bus.addr == OFS_REQ_SECOND) begin
            next_r.req.second = bus.wdata;
         end else if (bus.addr == OFS_REQ_MILLI) begin
            next_r.req.milli = bus.wdata;
         end else if (bus.addr == OFS_REQ_CLK_STATUS) begin
            next_r.req.clk_status = bus.wdata;
         end
      end
      // block control registers, open at all times
      if (bus.wr) begin
         if (bus.addr == OFS_CTRL) begin
            next_r.enable = bus.wdata[0];
         end else if (bus.addr == OFS_IRQ_MASK) begin
            next_r.irq_mask = bus.wdata[1:0];
         end else if (bus.addr == OFS_IRQ_STATUS) begin
            next_r.irq_status = r.irq_status & ~bus.wdata[1:0];
         end
      end
      // reads
      // read data stand for one cycle, zero otherwise
      if (bus.rd) begin
         if (bus.addr == OFS_REQ_COMMAND) begin
            next_r.rdata = r.req.command;
         end else if (bus.addr == OFS_REQ_YEAR) begin
            next_r.rdata = r.req.year;
         end else if (bus.addr == OFS_REQ_MONTH) begin
            next_r.rdata = r.req.month;
         end else if (bus.addr == OFS_REQ_DAY) begin
            next_r.rdata = r.req.day;
         end else if (bus.addr == OFS_REQ_HOUR) begin
            next_r.rdata = r.req.hour;
         end else if (bus.addr == OFS_REQ_MINUTE) begin
            next_r.rdata = r.req.minute;
         end else if (bus.addr == OFS_REQ_SECOND) begin
            next_r.rdata = r.req.second;
         end else if (bus.addr == OFS_REQ_MILLI) begin
            next_r.rdata = r.req.milli;
         end else if (bus.addr == OFS_REQ_CLK_STATUS) begin
            next_r.rdata = r.req.clk_status;
         end else if (bus.addr == OFS_RESP_CODE) begin
            next_r.rdata = r.resp_code; // see RULE10
         end else if (bus.addr >= OFS_RESP_PAD_FIRST && bus.addr <= OFS_RESP_PAD_LAST) begin
            next_r.rdata = PAD_VALUE; // see RULE11
         end else if (bus.addr == OFS_CTRL) begin
            next_r.rdata = {15'h0000, r.enable};
         end else if (bus.addr == OFS_IRQ_STATUS) begin
            next_r.rdata = {14'h0000, r.irq_status};
         end else if (bus.addr == OFS_IRQ_MASK) begin
            next_r.rdata = {14'h0000, r.irq_mask};
         end else if (bus.addr == OFS_ERR_LIMIT) begin
            next_r.rdata = r.err_count;
         end
      end
      // command handshake
      case (r.state)
         CTS_IDLE: begin
            next_r.done = 1'b0;
            if (req_lvl && r.enable) begin
               next_r.state = CTS_CHECK;
            end
         end
         CTS_CHECK: begin
            // command code is judged before the fields
            if (r.req.command != CMD_CAL_SET) begin
               next_r.resp_code = ERR_BAD_CMD; // see RULE12
               next_r.err_count = r.err_count + 16'h0001;
               next_r.irq_status[IRQ_ERR_BIT] = 1'b1;
            end else if (!range_ok) begin
               next_r.resp_code = ERR_BAD_RANGE; // see RULE17
               next_r.err_count = r.err_count + 16'h0001;
               next_r.irq_status[IRQ_ERR_BIT] = 1'b1;
            end else begin
               next_r.resp_code = RESP_CAL_DONE; // see RULE10
               next_r.tout = '{year: r.req.year, month: r.req.month, day: r.req.day,
                  hour: r.req.hour, minute: r.req.minute, second: r.req.second,
                  milli: r.req.milli, clk_status: r.req.clk_status, valid: 1'b1};
            end
            next_r.irq_status[IRQ_DONE_BIT] = 1'b1;
            next_r.done = 1'b1; // see RULE14
            next_r.state = CTS_DONE;
         end
         CTS_DONE: begin
            // hold done until the synced request falls
            if (!req_lvl) begin
               next_r.done = 1'b0; // see RULE16
               next_r.state = CTS_IDLE;
            end
         end
         default: begin
            next_r.state = CTS_IDLE;
         end
      endcase
      // level irq from the updated status and mask
      next_r.irq = |(next_r.irq_status & next_r.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         // enable comes up set so a first command runs
         r <= '0;
         r.state <= CTS_IDLE;
         r.enable <= 1'b1;
         r.irq_status <= RST_IRQ;
         r.irq_mask <= RST_IRQ;
      end else begin
         r <= next_r;
      end
   end

   assign bus_rdata_o = r.rdata;
   assign time_set_done_flag_o = r.done;
   assign time_set_o = r.tout;
   assign irq_o = r.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // handshake, response codes, month range and interrupt level
   property p_done_code;
      @(posedge sys_clk_i) disable iff (reset_i)
      $rose(r.done) |-> (r.resp_code == RESP_CAL_DONE) == $past(range_ok
         && r.req.command == CMD_CAL_SET);
   endproperty
   a_done_code: assert property (p_done_code) else $error("wrong response code"); // see RULE10

   property p_pad_zero;
      @(posedge sys_clk_i) disable iff (reset_i)
      (bus.rd && bus.addr >= OFS_RESP_PAD_FIRST && bus.addr <= OFS_RESP_PAD_LAST)
         |=> bus_rdata_o == PAD_VALUE;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("pad word not zero"); // see RULE11

   property p_err_code;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_CHECK && r.req.command != CMD_CAL_SET) |=> r.resp_code == ERR_BAD_CMD;
   endproperty
   a_err_code: assert property (p_err_code) else $error("bad command not flagged"); // see RULE12

   property p_done_after_check;
      @(posedge sys_clk_i) disable iff (reset_i)
      (req_lvl && r.state == CTS_IDLE && r.enable) |=> ##1 time_set_done_flag_o;
   endproperty
   a_done_after_check: assert property (p_done_after_check) else $error("done late"); // see RULE14

   property p_done_holds;
      @(posedge sys_clk_i) disable iff (reset_i)
      (time_set_done_flag_o && req_lvl) |=> time_set_done_flag_o;
   endproperty
   a_done_holds: assert property (p_done_holds) else $error("done dropped early"); // see RULE16

   property p_done_drops;
      @(posedge sys_clk_i) disable iff (reset_i)
      (time_set_done_flag_o && !req_lvl) |=> !time_set_done_flag_o;
   endproperty
   a_done_drops: assert property (p_done_drops) else $error("done stuck"); // see RULE16

   property p_range_err;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_CHECK && r.req.command == CMD_CAL_SET && r.req.month > MONTH_MAX)
         |=> r.resp_code == ERR_BAD_RANGE;
   endproperty
   a_range_err: assert property (p_range_err) else $error("range error missed"); // see RULE17

   property p_irq_level;
      @(posedge sys_clk_i) disable iff (reset_i)
      irq_o == |(r.irq_status & r.irq_mask);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

   // responses, ranges, handshake, time valid, enable, register port, error count and interrupt
   property p_good_code;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_CHECK && r.req.command == CMD_CAL_SET && range_ok)
         |=> r.resp_code == RESP_CAL_DONE && time_set_o.valid;
   endproperty
   a_good_code: assert property (p_good_code) else $error("good command refused"); // see RULE10

   property p_range_hour;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_CHECK && r.req.command == CMD_CAL_SET && r.req.hour > HOUR_MAX)
         |=> r.resp_code == ERR_BAD_RANGE;
   endproperty
   a_range_hour: assert property (p_range_hour) else $error("hour error missed"); // see RULE17

   property p_err_count;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_CHECK && !(r.req.command == CMD_CAL_SET && range_ok))
         |=> r.err_count == $past(r.err_count) + 16'h0001;
   endproperty
   a_err_count: assert property (p_err_count) else $error("error count not bumped"); // see RULE12

   property p_done_needs_req;
      @(posedge sys_clk_i) disable iff (reset_i)
      $rose(time_set_done_flag_o) |-> $past(req_lvl, 2);
   endproperty
   a_done_needs_req: assert property (p_done_needs_req) else $error("done without request"); // see RULE14

   property p_valid_pulse;
      @(posedge sys_clk_i) disable iff (reset_i)
      time_set_o.valid |=> !time_set_o.valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than a cycle");

   property p_irq_clear;
      @(posedge sys_clk_i) disable iff (reset_i)
      (bus.wr && bus.addr == OFS_IRQ_STATUS && bus.wdata[IRQ_DONE_BIT]
         && r.state != CTS_CHECK)
         |=> !r.irq_status[IRQ_DONE_BIT];
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

   property p_irq_set_wins;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_CHECK) |=> r.irq_status[IRQ_DONE_BIT];
   endproperty
   a_irq_set_wins: assert property (p_irq_set_wins) else $error("done status not set");

   property p_disabled_wait;
      @(posedge sys_clk_i) disable iff (reset_i)
      (r.state == CTS_IDLE && !r.enable) |=> r.state == CTS_IDLE;
   endproperty
   a_disabled_wait: assert property (p_disabled_wait) else $error("start while disabled");

   property p_rdata_idle;
      @(posedge sys_clk_i) disable iff (reset_i)
      !bus.rd |=> bus_rdata_o == RST_WORD;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

   property p_resp_read;
      @(posedge sys_clk_i) disable iff (reset_i)
      (bus.rd && bus.addr == OFS_RESP_CODE && r.resp_code == RESP_CAL_DONE)
         |=> bus_rdata_o == RESP_CAL_DONE;
   endproperty
   a_resp_read: assert property (p_resp_read) else $error("response code misread"); // see RULE10
endmodule : cts_time_set
`default_nettype wire

// *** tb/cts_host_model.sv ***
// host-side model: register port master and start handshake
`timescale 1ns/10ps
`default_nettype none
module cts_host_model (
   // clock
   input wire logic sys_clk_i,
   // register port
   output logic [cts_pkg::ADDR_W-1:0] bus_addr_o,
   output logic [cts_pkg::DATA_W-1:0] bus_wdata_o,
   output logic bus_wr_o,
   output logic bus_rd_o,
   input wire logic [cts_pkg::DATA_W-1:0] bus_rdata_i,
   // handshake
   output logic request_o,
   input wire logic done_i
);
   import cts_pkg::*;
   initial begin
      bus_addr_o = 16'h0000;
      bus_wdata_o = 16'h0000;
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
      request_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus_write(input logic [15:0] addr, input logic [15:0] data);
      @(posedge sys_clk_i);
      bus_addr_o <= addr;
      bus_wdata_o <= data;
      bus_wr_o <= 1'b1;
      @(posedge sys_clk_i);
      bus_wr_o <= 1'b0;
      bus_wdata_o <= ~data;
   endtask : bus_write
   task automatic bus_read(input logic [15:0] addr, output logic [15:0] data);
      @(posedge sys_clk_i);
      bus_addr_o <= addr;
      bus_rd_o <= 1'b1;
      @(posedge sys_clk_i);
      bus_rd_o <= 1'b0;
      #1 data = bus_rdata_i;
   endtask : bus_read
   ////////////////////////////////////////////////////////////////////////////////
   // whole command: words, start, wait, read code, release
   task automatic run_command(input logic [15:0] words [9], output logic [15:0] code,
                              output logic up_ok, output logic down_ok);
      int n;
      for (int i = 0; i < 9; i++) begin
         bus_write(OFS_REQ_COMMAND + 16'(i), words[i]);
      end
      @(posedge sys_clk_i);
      request_o <= 1'b1;
      n = 0;
      while (done_i !== 1'b1 && n < 20) begin
         @(posedge sys_clk_i);
         n++;
      end
      up_ok = (done_i === 1'b1);
      bus_read(OFS_RESP_CODE, code);
      @(posedge sys_clk_i);
      request_o <= 1'b0;
      n = 0;
      while (done_i !== 1'b0 && n < 10) begin
         @(posedge sys_clk_i);
         n++;
      end
      down_ok = (done_i === 1'b0);
   endtask : run_command
endmodule : cts_host_model
`default_nettype wire

// *** tb/cts_time_set_tb.sv ***
// self-checking bench for the calendar time-set block
`timescale 1ns/10ps
`default_nettype none
module cts_time_set_tb;
   import cts_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] bus_addr;
   logic [15:0] bus_wdata;
   logic bus_wr;
   logic bus_rd;
   logic [15:0] bus_rdata;
   logic request;
   logic done;
   logic irq;
   int valid_count = 0;
   cts_time_out_t tset;
   int failures = 0;
   int num_checks = 0;
   logic [15:0] good [9] = '{CMD_CAL_SET, 16'h07d5, 16'h0007, 16'h0001, 16'h000a,
                              16'h0000, 16'h0000, 16'h0000, 16'h0000};
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (tset.valid === 1'b1) begin
         valid_count <= valid_count + 1;
      end
   end
   cts_time_set uut (.sys_clk_i(sys_clk), .reset_i(reset), .bus_addr_i(bus_addr),
      .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata),
      .time_set_request_flag_i(request), .time_set_done_flag_o(done), .time_set_o(tset),
      .irq_o(irq));
   cts_host_model host (.sys_clk_i(sys_clk), .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata),
      .bus_wr_o(bus_wr), .bus_rd_o(bus_rd), .bus_rdata_i(bus_rdata), .request_o(request),
      .done_i(done));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   // one command, response code, handshake and empty words
   task automatic run_and_check(input logic [15:0] words [9], input logic [15:0] exp_code);
      logic [15:0] code;
      logic up_ok;
      logic down_ok;
      logic [15:0] pad;
      int vc;
      vc = valid_count;
      host.run_command(words, code, up_ok, down_ok);
      check(code, exp_code);
      check({15'h0000, up_ok}, 16'h0001);
      check({15'h0000, down_ok}, 16'h0001);
      check(16'(valid_count - vc), {15'h0000, exp_code == RESP_CAL_DONE});
      for (int a = OFS_RESP_PAD_FIRST; a <= OFS_RESP_PAD_LAST; a++) begin
         host.bus_read(16'(a), pad);
         check(pad, PAD_VALUE);
      end
   endtask : run_and_check
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset_values();
      logic [15:0] v;
      host.bus_read(OFS_CTRL, v);
      check(v, 16'h0001);
      host.bus_read(OFS_IRQ_MASK, v);
      check(v, 16'h0000);
      host.bus_read(OFS_RESP_CODE, v);
      check(v, 16'h0000);
      host.bus_read(16'h0100, v);
      check(v, 16'h0000);
      check({15'h0000, done}, 16'h0000);
   endtask : test_reset_values
   task automatic test_good_command();
      logic [15:0] v;
      host.bus_write(OFS_IRQ_MASK, 16'h0003);
      host.bus_read(OFS_IRQ_MASK, v);
      check(v, 16'h0003);
      run_and_check(good, RESP_CAL_DONE);
      check(tset.year, 16'h07d5);
      check(tset.month, 16'h0007);
      check(tset.day, 16'h0001);
      check(tset.hour, 16'h000a);
      check({15'h0000, irq}, 16'h0001);
      host.bus_write(OFS_IRQ_STATUS, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #1 check({15'h0000, irq}, 16'h0000);
   endtask : test_good_command
   task automatic test_boundaries();
      logic [15:0] w [9];
      w = '{CMD_CAL_SET, YEAR_MIN, MONTH_MIN, DAY_MIN, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 16'h0000};
      run_and_check(w, RESP_CAL_DONE);
      w = '{CMD_CAL_SET, YEAR_MAX, MONTH_MAX, DAY_MAX, HOUR_MAX, MINSEC_MAX, MINSEC_MAX,
            MILLI_MAX, 16'h00a5};
      run_and_check(w, RESP_CAL_DONE);
      check(tset.day, DAY_MAX);
      check(tset.minute, MINSEC_MAX);
      check(tset.second, MINSEC_MAX);
      check(tset.milli, MILLI_MAX);
      check(tset.clk_status, 16'h00a5);
   endtask : test_boundaries
   task automatic test_range_errors();
      logic [15:0] w [9];
      logic [15:0] v;
      int idx [10] = '{1, 1, 2, 2, 3, 3, 4, 5, 6, 7};
      logic [15:0] bad [10] = '{YEAR_MIN - 16'h0001, YEAR_MAX + 16'h0001,
         MONTH_MIN - 16'h0001, MONTH_MAX + 16'h0001, DAY_MIN - 16'h0001, DAY_MAX + 16'h0001,
         HOUR_MAX + 16'h0001, MINSEC_MAX + 16'h0001, MINSEC_MAX + 16'h0001,
         MILLI_MAX + 16'h0001};
      host.bus_write(OFS_IRQ_MASK, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         w = good;
         w[idx[i]] = bad[i];
         run_and_check(w, ERR_BAD_RANGE);
      end
      w = good;
      w[0] = 16'h1601;
      run_and_check(w, ERR_BAD_CMD);
      check({15'h0000, irq}, 16'h0000);
      host.bus_read(OFS_IRQ_STATUS, v);
      check(v, 16'h0003);
      host.bus_write(OFS_IRQ_STATUS, 16'h0002);
      host.bus_read(OFS_IRQ_STATUS, v);
      check(v, 16'h0001);
      host.bus_read(OFS_ERR_LIMIT, v);
      check(v, 16'h000b);
   endtask : test_range_errors
   // start held off while the block is disabled
   task automatic test_disabled();
      logic [15:0] v;
      logic up_ok;
      logic down_ok;
      int vc;
      host.bus_write(OFS_CTRL, 16'h0000);
      host.bus_read(OFS_CTRL, v);
      check(v, 16'h0000);
      vc = valid_count;
      host.run_command(good, v, up_ok, down_ok);
      check({15'h0000, up_ok}, 16'h0000);
      check({15'h0000, down_ok}, 16'h0001);
      check(v, ERR_BAD_CMD);
      check(16'(valid_count - vc), 16'h0000);
      host.bus_write(OFS_CTRL, 16'h0001);
      run_and_check(good, RESP_CAL_DONE);
   endtask : test_disabled
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      test_reset_values();
      test_good_command();
      test_boundaries();
      test_range_errors();
      test_disabled();
      finish_test();
   end
   initial begin
      #200000;
      failures++;
      finish_test();
   end
endmodule : cts_time_set_tb
`default_nettype wire
